// [ipdc_pkg.sv]
/*
  Shared constants, types and sequence functions for the IQ port input delay calibration.
  Assumes a 32-bit APB register bus with 12-bit byte addresses and a 16-bit sampled link.
*/
package ipdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int IPDC_DATA_W = 16;
  localparam int IPDC_ERR_W  = 21;
  localparam int IPDC_ADDR_W = 12;
  localparam int IPDC_SEL_W  = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern seeds, shift amounts and the first step, used as a self-check.
  // The Q step value is the one the three left shifts give with 16-bit truncation.
  localparam logic [15:0] IPDC_I_SEED  = 16'h306C;
  localparam logic [15:0] IPDC_Q_SEED  = 16'hFFFF;
  localparam logic [15:0] IPDC_I_STEP1 = 16'h696F;
  localparam logic [15:0] IPDC_Q_STEP1 = 16'h007F;
  localparam int IPDC_I_SH1 = 7;
  localparam int IPDC_I_SH2 = 9;
  localparam int IPDC_I_SH3 = 8;
  localparam int IPDC_Q_SH1 = 7;
  localparam int IPDC_Q_SH2 = 8;
  localparam int IPDC_Q_SH3 = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [11:0] IPDC_REG_CTRL   = 12'h000;
  localparam logic [11:0] IPDC_REG_CMD    = 12'h004;
  localparam logic [11:0] IPDC_REG_STATUS = 12'h008;
  localparam logic [11:0] IPDC_REG_SEL    = 12'h00C;
  localparam logic [11:0] IPDC_REG_ERRCNT = 12'h010;
  localparam logic [11:0] IPDC_REG_TAP    = 12'h014;

  // Field positions and reset values.
  localparam int IPDC_CTRL_STREAM = 0;
  localparam int IPDC_CTRL_MODSRC = 1;
  localparam int IPDC_CTRL_RATE   = 2;
  localparam logic [2:0] IPDC_CTRL_RST = 3'h0;
  localparam int IPDC_ST_BUSY     = 0;
  localparam int IPDC_ST_DONE     = 1;
  localparam int IPDC_ST_REFUSED  = 2;
  localparam int IPDC_ST_VALID    = 3;
  localparam int IPDC_ST_OVERFLOW = 4;
  localparam int IPDC_ST_TAP_LSB  = 8;
  localparam logic [31:0] IPDC_CAL_ARG = 32'h0000_0000;

  // Last sample slot of one sequence step: I,Q at the low rate, I,Q,I,Q at the high rate.
  localparam logic [1:0] IPDC_SLOT_LAST_SLOW = 2'h1;
  localparam logic [1:0] IPDC_SLOT_LAST_FAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // One captured link sample.
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ipdc_sample_t;

  typedef enum logic [1:0] {
    IPDC_IDLE,
    IPDC_SWEEP,
    IPDC_APPLY
  } ipdc_state_t;

  // One step of the I sequence; every shift truncates to 16 bits.
  function automatic logic [15:0] ipdc_step_i(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << IPDC_I_SH1);
    t = t ^ (t >> IPDC_I_SH2);
    t = t ^ (t << IPDC_I_SH3);
    return t;
  endfunction

  // One step of the Q sequence.
  function automatic logic [15:0] ipdc_step_q(input logic [15:0] v);
    logic [15:0] t;
    t = v ^ (v << IPDC_Q_SH1);
    t = t ^ (t << IPDC_Q_SH2);
    t = t ^ (t << IPDC_Q_SH3);
    return t;
  endfunction

endpackage

// [ipdc_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, width and depth as parameters.
  Assumes one clock, an active-low asynchronous reset and a clock enable.
*/
module ipdc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0]   wr_ptr_ff;
  logic [PTR_W:0]   rd_ptr_ff;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////////
  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = !((wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]) &&
                       (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]));
  assign out_valid = (wr_ptr_ff != rd_ptr_ff);
  assign out_data  = mem[rd_ptr_ff[PTR_W-1:0]];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  // Storage is not reset; only entries between the pointers are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[PTR_W-1:0]] <= in_data;
    end
  end

  // Write pointer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  // Read pointer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule

// [ipdc_top.sv]
/*
  Input delay calibration for a source-synchronous 16-bit IQ port with valid and link clock.
  Assumes the link pins are asynchronous to CLK and much slower than it, and an APB master.
*/
// Our own choices: the register offsets and the APB interface to the registers.
// Summary of operation
// - Samples taken while valid is low are ignored by calibration.
// - Received data is checked against the built-in test pattern sequences.
// - I sequence starts from 0x306C, Q sequence from 0xFFFF.
// - I steps shift 7 left, 9 right, 8 left; Q 7, 8, 8 left.
// - A valid period may start at any step if Q follows matching.
// - Start command with argument 0 after stream, rate and source are set.
// - Each data bit gets its own input delay tap.
// - Data and valid are sampled on each rising link clock edge.
module ipdc_top #(
  parameter int NUM_TAPS = 32,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                                 CLK,
  input  wire logic                                 RESET_N,
  input  wire logic                                 CE,
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [ipdc_pkg::IPDC_ADDR_W-1:0]     PADDR,
  input  wire logic [31:0]                          PWDATA,
  output logic      [31:0]                          PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR,
  input  wire logic                                 LINK_CLK,
  input  wire logic                                 LINK_VALID,
  input  wire logic [ipdc_pkg::IPDC_DATA_W-1:0]     LINK_DATA,
  output logic      [ipdc_pkg::IPDC_DATA_W-1:0][$clog2(NUM_TAPS)-1:0] DELAY_TAP
);
  import ipdc_pkg::*;

  localparam int TAP_W = $clog2(NUM_TAPS);
  localparam int LEN_W = TAP_W + 1;
  localparam logic [TAP_W-1:0] TAP_LAST = TAP_W'(NUM_TAPS - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [2:0]             lclk_sync_ff;
  logic [1:0]             lvld_sync_ff;
  logic [15:0]            ldat_s1_ff;
  logic [15:0]            ldat_s2_ff;
  logic                   link_rise;
  ipdc_sample_t           cap_ff;
  logic                   cap_vld_ff;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  ipdc_sample_t           fifo_out;
  logic                   chk_ready;
  logic                   pop;
  logic                   rise;
  logic                   fall;
  logic                   compare_en;
  logic [15:0]            expect_val;
  logic [15:0]            err_vec;
  logic [1:0]             slot_last;
  logic                   prev_valid_ff;
  logic                   aligned_ff;
  logic [1:0]             slot_ff;
  logic [15:0]            ref_i_ff;
  logic [15:0]            ref_q_ff;
  logic [15:0]            err_seen_ff;
  logic                   cmp_seen_ff;
  logic                   period_open_ff;
  logic                   evaluate;
  ipdc_state_t            state_ff;
  logic [TAP_W-1:0]       trial_ff;
  logic                   rate_ff;
  logic [2:0]             ctrl_ff;
  logic [IPDC_SEL_W-1:0]  sel_ff;
  logic                   done_ff;
  logic                   refused_ff;
  logic                   overflow_ff;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic [31:0]            prdata_ff;
  logic                   access;
  logic                   wr_en;
  logic                   cmd_wr;
  logic                   start_ok;
  logic [31:0]            rd_mux;
  logic                   rd_hit;
  logic [IPDC_ERR_W-1:0]  err_cnt_ff [IPDC_DATA_W];
  logic [LEN_W-1:0]       run_len_ff [IPDC_DATA_W];
  logic [LEN_W-1:0]       best_len_ff [IPDC_DATA_W];
  logic [TAP_W-1:0]       best_start_ff [IPDC_DATA_W];
  logic [TAP_W-1:0]       center [IPDC_DATA_W];
  logic [TAP_W-1:0]       delay_ff [IPDC_DATA_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Link pins pass two flops; edges are found on the second and third stage only.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lclk_sync_ff <= '0;
      lvld_sync_ff <= '0;
      ldat_s1_ff   <= '0;
      ldat_s2_ff   <= '0;
    end else if (CE) begin
      lclk_sync_ff <= {lclk_sync_ff[1:0], LINK_CLK};
      lvld_sync_ff <= {lvld_sync_ff[0], LINK_VALID};
      ldat_s1_ff   <= LINK_DATA;
      ldat_s2_ff   <= ldat_s1_ff;
    end
  end

  assign link_rise = lclk_sync_ff[1] && !lclk_sync_ff[2];

  // One sample per link clock rising edge, pushed only while a calibration runs.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_ff     <= '0;
      cap_vld_ff <= 1'b0;
    end else if (CE) begin
      cap_vld_ff <= link_rise && (state_ff == IPDC_SWEEP);
      if (link_rise) begin
        cap_ff.valid <= lvld_sync_ff[1];
        cap_ff.data  <= ldat_s2_ff;
      end
    end
  end

  // The FIFO decouples capture from the checker, which stalls during the apply cycle.
  ipdc_fifo #(
    .WIDTH ($bits(ipdc_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .ce        (CE),
    .in_valid  (cap_vld_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_ff),
    .out_valid (fifo_out_valid),
    .out_ready (chk_ready),
    .out_data  (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checker decode of the popped sample.
  assign chk_ready  = (state_ff != IPDC_APPLY);
  assign pop        = CE && fifo_out_valid && chk_ready;
  assign rise       = pop && fifo_out.valid && !prev_valid_ff;
  assign fall       = pop && !fifo_out.valid && prev_valid_ff;
  assign slot_last  = rate_ff ? IPDC_SLOT_LAST_FAST : IPDC_SLOT_LAST_SLOW;
  assign compare_en = pop && fifo_out.valid && !rise && aligned_ff;
  assign expect_val = slot_ff[0] ? ref_q_ff : ref_i_ff;
  assign err_vec    = compare_en ? (fifo_out.data ^ expect_val) : '0;
  assign evaluate   = fall && period_open_ff && (state_ff == IPDC_SWEEP);

  // Reference generator: reload from the first I/Q pair of each period, then step.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prev_valid_ff <= 1'b0;
      aligned_ff    <= 1'b0;
      slot_ff       <= '0;
      ref_i_ff      <= IPDC_I_SEED;
      ref_q_ff      <= IPDC_Q_SEED;
    end else if (pop) begin
      prev_valid_ff <= fifo_out.valid;
      if (rise) begin
        ref_i_ff   <= fifo_out.data;
        slot_ff    <= 2'h1;
        aligned_ff <= 1'b0;
      end else if (fifo_out.valid && !aligned_ff) begin
        ref_q_ff   <= fifo_out.data;
        aligned_ff <= 1'b1;
        if (slot_last == IPDC_SLOT_LAST_SLOW) begin
          ref_i_ff <= ipdc_step_i(ref_i_ff);
          ref_q_ff <= ipdc_step_q(fifo_out.data);
          slot_ff  <= '0;
        end else begin
          slot_ff <= slot_ff + 2'h1;
        end
      end else if (fifo_out.valid) begin
        if (slot_ff == slot_last) begin
          ref_i_ff <= ipdc_step_i(ref_i_ff);
          ref_q_ff <= ipdc_step_q(ref_q_ff);
          slot_ff  <= '0;
        end else begin
          slot_ff <= slot_ff + 2'h1;
        end
      end
    end
  end

  // Per-period pass tracking; a rise never carries a comparison, so no set/clear clash.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_seen_ff    <= '0;
      cmp_seen_ff    <= 1'b0;
      period_open_ff <= 1'b0;
    end else if (pop) begin
      if (rise) begin
        err_seen_ff    <= '0;
        cmp_seen_ff    <= 1'b0;
        period_open_ff <= (state_ff == IPDC_SWEEP);
      end else begin
        err_seen_ff <= err_seen_ff | err_vec;
        cmp_seen_ff <= cmp_seen_ff | compare_en;
        if (fall) begin
          period_open_ff <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sweep sequencer: one trial tap per valid period, then apply the window centres.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= IPDC_IDLE;
      trial_ff <= '0;
      rate_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else if (CE) begin
      case (state_ff)
        IPDC_IDLE: begin
          if (start_ok) begin
            state_ff <= IPDC_SWEEP;
            trial_ff <= '0;
            rate_ff  <= ctrl_ff[IPDC_CTRL_RATE];
            done_ff  <= 1'b0;
          end
        end
        IPDC_SWEEP: begin
          if (evaluate) begin
            if (trial_ff == TAP_LAST) begin
              state_ff <= IPDC_APPLY;
            end else begin
              trial_ff <= trial_ff + 1'b1;
            end
          end
        end
        IPDC_APPLY: begin
          state_ff <= IPDC_IDLE;
          done_ff  <= 1'b1;
        end
        default: begin
          state_ff <= IPDC_IDLE;
        end
      endcase
    end
  end

  // Per-bit error counters, pass windows and delay taps.
  for (genvar b = 0; b < IPDC_DATA_W; b++) begin : g_bit
    assign center[b] = best_start_ff[b] + TAP_W'(best_len_ff[b] >> 1);

    // Error totals wrap at their width; they restart with each calibration.
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        err_cnt_ff[b] <= '0;
      end else if (CE) begin
        if (start_ok) begin
          err_cnt_ff[b] <= '0;
        end else if (err_vec[b]) begin
          err_cnt_ff[b] <= err_cnt_ff[b] + 1'b1;
        end
      end
    end

    // Longest run of error-free taps; an empty period counts as a failure.
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        run_len_ff[b]    <= '0;
        best_len_ff[b]   <= '0;
        best_start_ff[b] <= '0;
      end else if (CE) begin
        if (start_ok) begin
          run_len_ff[b]  <= '0;
          best_len_ff[b] <= '0;
        end else if (evaluate) begin
          if (cmp_seen_ff && !err_seen_ff[b]) begin
            run_len_ff[b] <= run_len_ff[b] + 1'b1;
            if (run_len_ff[b] + 1'b1 > best_len_ff[b]) begin
              best_len_ff[b]   <= run_len_ff[b] + 1'b1;
              best_start_ff[b] <= trial_ff - TAP_W'(run_len_ff[b]);
            end
          end else begin
            run_len_ff[b] <= '0;
          end
        end
      end
    end

    // The whole bus takes the trial tap during the sweep, each bit with a pass window its own centre after.
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        delay_ff[b] <= '0;
      end else if (CE) begin
        if (state_ff == IPDC_SWEEP) begin
          delay_ff[b] <= trial_ff;
        end else if (state_ff == IPDC_APPLY && best_len_ff[b] != '0) begin
          delay_ff[b] <= center[b];
        end
      end
    end

    assign DELAY_TAP[b] = delay_ff[b];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write takes effect at the edge that sees PREADY high.
  assign access   = PSEL && PENABLE;
  assign wr_en    = CE && access && pready_ff && PWRITE;
  assign cmd_wr   = wr_en && (PADDR == IPDC_REG_CMD);
  assign start_ok = cmd_wr && (PWDATA == IPDC_CAL_ARG) && (state_ff == IPDC_IDLE) &&
                    ctrl_ff[IPDC_CTRL_STREAM] && ctrl_ff[IPDC_CTRL_MODSRC];
  assign PREADY   = pready_ff;
  assign PSLVERR  = pslverr_ff;
  assign PRDATA   = prdata_ff;

  // Read decode; unmapped addresses read zero and answer with an error.
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (PADDR)
      IPDC_REG_CTRL:   rd_mux[2:0] = ctrl_ff;
      IPDC_REG_CMD:    rd_mux = '0;
      IPDC_REG_STATUS: begin
        rd_mux[IPDC_ST_BUSY]     = (state_ff != IPDC_IDLE);
        rd_mux[IPDC_ST_DONE]     = done_ff;
        rd_mux[IPDC_ST_REFUSED]  = refused_ff;
        rd_mux[IPDC_ST_VALID]    = lvld_sync_ff[1];
        rd_mux[IPDC_ST_OVERFLOW] = overflow_ff;
        rd_mux[IPDC_ST_TAP_LSB +: TAP_W] = trial_ff;
      end
      IPDC_REG_SEL:    rd_mux[IPDC_SEL_W-1:0] = sel_ff;
      IPDC_REG_ERRCNT: rd_mux[IPDC_ERR_W-1:0] = err_cnt_ff[sel_ff];
      IPDC_REG_TAP:    rd_mux[TAP_W-1:0] = delay_ff[sel_ff];
      default:         rd_hit = 1'b0;
    endcase
  end

  // Handshake and read data flops.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (CE) begin
      pready_ff  <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && !rd_hit;
      if (access && !pready_ff && !PWRITE) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // Software registers; changing them during a sweep does not disturb the latched rate.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff <= IPDC_CTRL_RST;
      sel_ff  <= '0;
    end else if (wr_en) begin
      if (PADDR == IPDC_REG_CTRL) begin
        ctrl_ff <= PWDATA[2:0];
      end
      if (PADDR == IPDC_REG_SEL) begin
        sel_ff <= PWDATA[IPDC_SEL_W-1:0];
      end
    end
  end

  // Sticky flags: refused start commands and capture overflow, cleared by a good start.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      refused_ff  <= 1'b0;
      overflow_ff <= 1'b0;
    end else if (CE) begin
      if (cmd_wr && !start_ok) begin
        refused_ff <= 1'b1;
      end else if (start_ok) begin
        refused_ff <= 1'b0;
      end
      if (cap_vld_ff && !fifo_in_ready) begin
        overflow_ff <= 1'b1;
      end else if (start_ok) begin
        overflow_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rise_pop;
    pop && fifo_out.valid && !prev_valid_ff;
  endsequence

  sequence s_q_align_slow;
    pop && fifo_out.valid && !rise && !aligned_ff && !rate_ff;
  endsequence

  chk_seq_first_step: assert property (
    ipdc_step_i(IPDC_I_SEED) == IPDC_I_STEP1 && ipdc_step_q(IPDC_Q_SEED) == IPDC_Q_STEP1)
    else $error("Pattern step from seed gives wrong value.");

  chk_invalid_excluded: assert property (
    (pop && !fifo_out.valid) |=> $stable(err_seen_ff) && (err_cnt_ff[0] == $past(err_cnt_ff[0])))
    else $error("Invalid sample affected the error state.");

  chk_realign_i: assert property (
    s_rise_pop |=> (ref_i_ff == $past(fifo_out.data)) && !aligned_ff && (slot_ff == 2'h1))
    else $error("Reference not reloaded from the I sample at valid rise.");

  chk_slow_step: assert property (
    s_q_align_slow |=> (ref_q_ff == ipdc_step_q($past(fifo_out.data))) && aligned_ff)
    else $error("Q reference not stepped after alignment at the low rate.");

  chk_start_cmd: assert property (
    start_ok |=> (state_ff == IPDC_SWEEP) && (trial_ff == '0) && !done_ff)
    else $error("Accepted start command did not begin the sweep.");

  chk_refuse_arg: assert property (
    (cmd_wr && PWDATA != IPDC_CAL_ARG && state_ff == IPDC_IDLE) |=>
      (state_ff == IPDC_IDLE) && refused_ff)
    else $error("Nonzero start argument was not refused.");

  chk_tap_advance: assert property (
    (evaluate && CE && trial_ff != TAP_LAST) |=> (trial_ff == $past(trial_ff) + 1'b1) ##1
      (delay_ff[0] == trial_ff))
    else $error("Trial tap did not advance to the bits after a period.");

  chk_capture_edge: assert property (
    (CE && link_rise && state_ff == IPDC_SWEEP) |=>
      cap_vld_ff && (cap_ff.data == $past(ldat_s2_ff)))
    else $error("Link sample not captured at the link clock edge.");

  chk_apb_wait: assert property (
    (access && !pready_ff && CE) |=> pready_ff ##1 !pready_ff)
    else $error("APB answer not given after one wait state.");

endmodule

// [ipdc_sender.sv]
/*
  Sender model: a free link clock, valid periods and the I/Q test pattern.
  Assumes the bench sets fast and calls burst once for each valid period.
*/
module ipdc_sender (
  output logic        link_clk,
  output logic        link_valid,
  output logic [15:0] link_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast;
  logic busy;
  // The link clock is continuous, so it runs between periods too.
  initial begin
    fast = 1'b0;
    busy = 1'b0;
    link_valid = 1'b0;
    link_data = 16'h5A5A;
    link_clk = 1'b0;
    forever #40 link_clk = ~link_clk;
  end
  // Outside a period the data wander, so a stale word can never pass as valid.
  always @(posedge link_clk) if (!busy) link_data <= link_data * 16'h0005 + 16'h3B1D;
  // One pattern step; every shift drops bits above 16.
  function automatic logic [15:0] mix(input logic [15:0] v, input bit iseq);
    v = v ^ (v << 7);
    v = iseq ? v ^ (v >> 9) : v ^ (v << 8);
    return v ^ (v << 8);
  endfunction
  // One valid period of len samples from step skip; mask flips compared slots only.
  task automatic burst(input int skip, input int len, input logic [15:0] mask);
    logic [15:0] i;
    logic [15:0] q;
    i = 16'h306C;
    q = 16'hFFFF;
    busy = 1'b1;
    for (int k = -skip; k < len; k++) begin
      if (k >= 0) begin
        @(posedge link_clk);
        link_valid <= 1'b1;
        link_data <= (k[0] ? q : i) ^ (k > 1 ? mask : 16'h0000);
      end
      if (k < 0 || (k[0] && (!fast || k[1]))) begin
        i = mix(i, 1'b1);
        q = mix(q, 1'b0);
      end
    end
    @(posedge link_clk);
    link_valid <= 1'b0;
    busy = 1'b0;
    // Periods are scaled far below seconds to keep the run short.
    repeat (5) @(posedge link_clk);
  endtask
endmodule

// [iq_port_delay_calibration_bench.sv]
/*
  Bench for the delay calibration: APB master, sender model and result checks.
  Assumes four taps, so four valid periods make one calibration.
*/
module iq_port_delay_calibration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ipdc_pkg::*;
  logic             clk, reset_n, psel, penable, pwrite, er, ce;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, rd;
  wire  [31:0]      prdata;
  wire              pready, pslverr, lclk, lval;
  wire  [15:0]      ldat;
  wire  [15:0][1:0] tap;
  int               errors, checked, cyc;
  ipdc_top #(.NUM_TAPS(4), .FIFO_DEPTH(8)) uut (.CLK(clk), .RESET_N(reset_n), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK_CLK(lclk),
    .LINK_VALID(lval), .LINK_DATA(ldat), .DELAY_TAP(tap));
  ipdc_sender snd (.link_clk(lclk), .link_valid(lval), .link_data(ldat));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("Counts: %0d errors, %0d checked", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset values, then an unmapped address, which must be refused.
  task automatic s_reset;
    check(32'(tap), 32'h0);
    apb(1'b0, IPDC_REG_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, IPDC_REG_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
  endtask
  // With the clock enable low the slave must not answer; the write lands once it is high.
  task automatic s_freeze;
    ce <= 1'b0;
    fork
      apb(1'b1, IPDC_REG_SEL, 32'h5);
    join_none
    repeat (4) @(posedge clk);
    check({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    wait fork;
    apb(1'b0, IPDC_REG_SEL, 32'h0);
    check(rd, 32'h5);
  endtask
  // A start before the port is enabled, and one with a wrong argument.
  task automatic s_refuse;
    apb(1'b1, IPDC_REG_CMD, IPDC_CAL_ARG);
    apb(1'b0, IPDC_REG_STATUS, 32'h0);
    check(rd, 32'h4);
    apb(1'b1, IPDC_REG_CTRL, 32'h3);
    apb(1'b1, IPDC_REG_CMD, 32'h1);
    apb(1'b0, IPDC_REG_STATUS, 32'h0);
    check(rd, 32'h4);
  endtask
  // Full calibration; bit b is corrupted in the periods flagged in badp.
  task automatic s_cal(input logic f, input int b, input logic [3:0] badp,
                       input logic [31:0] et, input logic [31:0] ee);
    snd.fast = f;
    apb(1'b1, IPDC_REG_CTRL, {29'h0, f, 2'h3});
    apb(1'b1, IPDC_REG_CMD, IPDC_CAL_ARG);
    apb(1'b0, IPDC_REG_STATUS, 32'h0);
    check(rd & 32'h5, 32'h1);
    for (int p = 0; p < 4; p++) snd.burst(3 * p + 1, 12, badp[p] ? 16'h1 << b : 16'h0);
    for (int n = 0; n < 50 && rd[1] !== 1'b1; n++) apb(1'b0, IPDC_REG_STATUS, 32'h0);
    check(32'(rd[4:0]), 32'h2);
    check(32'(tap[b]), et);
    check(32'(tap[15 - b]), 32'h2);
    apb(1'b1, IPDC_REG_SEL, 32'(b));
    apb(1'b0, IPDC_REG_ERRCNT, 32'h0);
    check(rd, ee);
    apb(1'b0, IPDC_REG_TAP, 32'h0);
    check(rd, et);
  endtask
  // The clock, and a ceiling on the whole run.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      close_out;
    end
  end
  // Main sequence: reset for four cycles, then the scenarios.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, reset_n} = '0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    s_reset;
    s_freeze;
    s_refuse;
    s_cal(1'b0, 3, 4'h3, 32'h3, 32'd20);
    s_cal(1'b1, 5, 4'h8, 32'h1, 32'd10);
    close_out;
  end
endmodule
